//--- verilog/afecr_pkg.sv
// constants for the analog front end control register bank
// assumes a byte-wide register port with one-cycle strobes on the system clock
// Functional notes
// R1: the D/A converter is held in reset while its reset-hold bit is 1 and released when software writes it to 0.
// R2: the D/A converter clock is stopped while its clock-gate bit is 0 and supplied while it is 1.
// R3: an 8-bit code register sets the analog level that the D/A converter drives.
// R4: with the gain amplifier clock gate at 0 its register cannot be written and is not initialized; at 1 it is read/write.
// R5: one bit picks the feedback network ground, 0 for the main supply ground, 1 for the amplifier ground pin.
// R6: the 2-bit gain field selects gain 4, 8, 16 or 32 for codes 00, 01, 10 and 11.
// R7: the comparator clock is stopped while its clock-gate bit is 0 and supplied while it is 1.
// R8: comparator 1 runs only while its enable bit in the mode register is 1.
// R9: comparator 0 runs only while its enable bit in the mode register is 1.
// R10: one request flag per comparator in the low flag register reads 1 while a request is pending.
// R11: one mask bit per comparator blocks servicing of its request when 1 and allows it when 0.
// R12: the comparator module is held in reset while its reset-hold bit is 1 and released when written to 0.
// R13: software clears pending comparator flags and sets masks as needed before operation.
// R14: a detection event sets its request flag whatever the mask, and the flag stays until software clears it.
package afecr_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int N_CMP  = 2;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_RESET_CTL  = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CLOCK_GATE = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_DAC_CODE   = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_AMP_CTL    = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_CMP_MODE   = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_FLAGS  = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASKS  = 4'h6;

  // field positions
  localparam int DAC_RESET_BIT  = 7;
  localparam int CMP_RESET_BIT  = 5;
  localparam int AMP_RESET_BIT  = 2;
  localparam int DAC_GATE_BIT   = 7;
  localparam int CMP_GATE_BIT   = 5;
  localparam int AMP_GATE_BIT   = 2;
  localparam int AMP_ENABLE_BIT = 7;
  localparam int GROUND_SEL_BIT = 3;
  localparam int GAIN_LSB       = 0;
  localparam int GAIN_W         = 2;
  localparam int CMP_EN_BIT [N_CMP] = '{0, 4};

  // writable bits per register
  localparam logic [DATA_W-1:0] MASK_RESET_CTL  = 8'ha4;
  localparam logic [DATA_W-1:0] MASK_CLOCK_GATE = 8'ha4;
  localparam logic [DATA_W-1:0] MASK_AMP_CTL    = 8'h8b;
  localparam logic [N_CMP-1:0]  MASK_CMP_BITS   = 2'h3;

  // reset values
  localparam logic [DATA_W-1:0] RST_RESET_CTL  = 8'h00;
  localparam logic [DATA_W-1:0] RST_CLOCK_GATE = 8'h00;
  localparam logic [DATA_W-1:0] RST_DAC_CODE   = 8'h00;
  localparam logic [DATA_W-1:0] RST_AMP_CTL    = 8'h00;
  localparam logic [DATA_W-1:0] RST_CMP_MODE   = 8'h00;
  localparam logic [N_CMP-1:0]  RST_IRQ_FLAGS  = 2'h0;
  localparam logic [N_CMP-1:0]  RST_IRQ_MASKS  = 2'h3;

  // gain factors by code
  localparam int GAIN_FACT_W = 6;
  localparam logic [GAIN_FACT_W-1:0] GAIN_X4  = 6'h04;
  localparam logic [GAIN_FACT_W-1:0] GAIN_X8  = 6'h08;
  localparam logic [GAIN_FACT_W-1:0] GAIN_X16 = 6'h10;
  localparam logic [GAIN_FACT_W-1:0] GAIN_X32 = 6'h20;
endpackage

//--- verilog/afecr_regs.sv
// register bank for the analog front end: reset holds, clock gates, dac code,
// gain amplifier setup, comparator enables and comparator request/mask flags
// assumes a same-clock register master and asynchronous comparator outputs
`timescale 1ns/1ns
module afecr_regs (
  input  wire logic                                 i_clk_sys,
  input  wire logic                                 i_arst_n,
  input  wire logic [afecr_pkg::ADDR_W-1:0]         i_addr,
  input  wire logic [afecr_pkg::DATA_W-1:0]         i_wdata,
  input  wire logic                                 i_wr,
  input  wire logic                                 i_rd,
  output logic      [afecr_pkg::DATA_W-1:0]         o_rdata,
  input  wire logic [afecr_pkg::N_CMP-1:0]          i_cmp_out,
  output logic                                      o_dac_reset,
  output logic                                      o_dac_clk_en,
  output logic      [afecr_pkg::DATA_W-1:0]         o_dac_code,
  output logic                                      o_amp_reset,
  output logic                                      o_amp_clk_en,
  output logic                                      o_amp_enable,
  output logic                                      o_feedback_ground_select,
  output logic      [afecr_pkg::GAIN_FACT_W-1:0]    o_gain_factor,
  output logic                                      o_cmp_reset,
  output logic                                      o_cmp_clk_en,
  output logic      [afecr_pkg::N_CMP-1:0]          o_cmp_enable,
  output logic      [afecr_pkg::DATA_W-1:0]         o_cmp_mode,
  output logic      [afecr_pkg::N_CMP-1:0]          o_irq_pending
);

  logic [afecr_pkg::DATA_W-1:0]      reset_ctl;
  logic [afecr_pkg::DATA_W-1:0]      clock_gate;
  logic [afecr_pkg::DATA_W-1:0]      dac_code;
  logic [afecr_pkg::DATA_W-1:0]      amp_ctl;
  logic [afecr_pkg::DATA_W-1:0]      cmp_mode;
  logic [afecr_pkg::N_CMP-1:0]       irq_flags;
  logic [afecr_pkg::N_CMP-1:0]       irq_masks;
  logic [afecr_pkg::N_CMP-1:0]       cmp_sync1;
  logic [afecr_pkg::N_CMP-1:0]       cmp_sync2;
  logic [afecr_pkg::N_CMP-1:0]       cmp_prev;
  logic [afecr_pkg::N_CMP-1:0]       cmp_event;
  logic [afecr_pkg::N_CMP-1:0]       cmp_active;
  logic [afecr_pkg::N_CMP-1:0]       next_irq_flags;
  logic [afecr_pkg::GAIN_FACT_W-1:0] next_gain_factor;
  logic [afecr_pkg::DATA_W-1:0]      next_dac_code_out;
  logic [afecr_pkg::DATA_W-1:0]      rd_mux;

  // address decode
  wire sel_reset_ctl  = (i_addr == afecr_pkg::OFS_RESET_CTL);
  wire sel_clock_gate = (i_addr == afecr_pkg::OFS_CLOCK_GATE);
  wire sel_dac_code   = (i_addr == afecr_pkg::OFS_DAC_CODE);
  wire sel_amp_ctl    = (i_addr == afecr_pkg::OFS_AMP_CTL);
  wire sel_cmp_mode   = (i_addr == afecr_pkg::OFS_CMP_MODE);
  wire sel_irq_flags  = (i_addr == afecr_pkg::OFS_IRQ_FLAGS);
  wire sel_irq_masks  = (i_addr == afecr_pkg::OFS_IRQ_MASKS);

  wire wr_reset_ctl  = i_wr && sel_reset_ctl;
  wire wr_clock_gate = i_wr && sel_clock_gate;
  wire wr_dac_code   = i_wr && sel_dac_code;
  wire wr_amp_ctl    = i_wr && sel_amp_ctl;
  wire wr_cmp_mode   = i_wr && sel_cmp_mode;
  wire wr_irq_flags  = i_wr && sel_irq_flags;
  wire wr_irq_masks  = i_wr && sel_irq_masks;

  // control fields
  wire dac_hold  = reset_ctl[afecr_pkg::DAC_RESET_BIT];
  wire cmp_hold  = reset_ctl[afecr_pkg::CMP_RESET_BIT];
  wire amp_hold  = reset_ctl[afecr_pkg::AMP_RESET_BIT];
  wire dac_gate  = clock_gate[afecr_pkg::DAC_GATE_BIT];
  wire cmp_gate  = clock_gate[afecr_pkg::CMP_GATE_BIT];
  wire amp_gate  = clock_gate[afecr_pkg::AMP_GATE_BIT];
  wire [afecr_pkg::GAIN_W-1:0] gain_sel = amp_ctl[afecr_pkg::GAIN_LSB +: afecr_pkg::GAIN_W];

  // amplifier register writable only with its clock supplied
  wire amp_wr_ok   = wr_amp_ctl && amp_gate;  // [R4]
  wire amp_init_ok = amp_hold && amp_gate;    // [R4]

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      reset_ctl <= afecr_pkg::RST_RESET_CTL;
    end else if (wr_reset_ctl) begin
      reset_ctl <= i_wdata & afecr_pkg::MASK_RESET_CTL;  // [R1] [R12]
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      clock_gate <= afecr_pkg::RST_CLOCK_GATE;
    end else if (wr_clock_gate) begin
      clock_gate <= i_wdata & afecr_pkg::MASK_CLOCK_GATE;  // [R2] [R7]
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dac_code <= afecr_pkg::RST_DAC_CODE;
    end else if (dac_hold) begin
      dac_code <= afecr_pkg::RST_DAC_CODE;  // [R1]
    end else if (wr_dac_code) begin
      dac_code <= i_wdata;  // [R3]
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      amp_ctl <= afecr_pkg::RST_AMP_CTL;
    end else if (amp_init_ok) begin
      amp_ctl <= afecr_pkg::RST_AMP_CTL;  // [R4]
    end else if (amp_wr_ok) begin
      amp_ctl <= i_wdata & afecr_pkg::MASK_AMP_CTL;  // [R4] [R5] [R6]
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cmp_mode <= afecr_pkg::RST_CMP_MODE;
    end else if (cmp_hold) begin
      cmp_mode <= afecr_pkg::RST_CMP_MODE;  // [R12]
    end else if (wr_cmp_mode) begin
      cmp_mode <= i_wdata;  // [R8] [R9]
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_masks <= afecr_pkg::RST_IRQ_MASKS;
    end else if (wr_irq_masks) begin
      irq_masks <= i_wdata[afecr_pkg::N_CMP-1:0] & afecr_pkg::MASK_CMP_BITS;  // [R11]
    end
  end

  // gain decode
  assign next_gain_factor = (gain_sel == 2'h0) ? afecr_pkg::GAIN_X4 :
                            (gain_sel == 2'h1) ? afecr_pkg::GAIN_X8 :
                            (gain_sel == 2'h2) ? afecr_pkg::GAIN_X16 :
                                                 afecr_pkg::GAIN_X32;  // [R6]

  // converter sees its code only while clocked and out of reset
  assign next_dac_code_out = (dac_gate && !dac_hold) ? dac_code : afecr_pkg::RST_DAC_CODE;  // [R2] [R3]

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_gain_factor <= afecr_pkg::GAIN_X4;
      o_dac_code    <= afecr_pkg::RST_DAC_CODE;
    end else begin
      o_gain_factor <= next_gain_factor;
      o_dac_code    <= next_dac_code_out;
    end
  end

  // per-comparator synchroniser, edge detect and request flag
  genvar gi;
  generate
    for (gi = 0; gi < afecr_pkg::N_CMP; gi++) begin : g_cmp
      assign cmp_active[gi] = cmp_gate && !cmp_hold && cmp_mode[afecr_pkg::CMP_EN_BIT[gi]];  // [R7] [R8] [R9] [R12]
      assign cmp_event[gi]  = cmp_active[gi] && cmp_sync2[gi] && !cmp_prev[gi];
      // event beats a software clear in the same cycle
      assign next_irq_flags[gi] = cmp_event[gi] | (wr_irq_flags ? i_wdata[gi] : irq_flags[gi]);  // [R10] [R14]

      always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
          cmp_sync1[gi] <= 1'b0;
          cmp_sync2[gi] <= 1'b0;
          cmp_prev[gi]  <= 1'b0;
          irq_flags[gi] <= afecr_pkg::RST_IRQ_FLAGS[gi];
          o_irq_pending[gi] <= 1'b0;
        end else begin
          cmp_sync1[gi] <= i_cmp_out[gi];
          cmp_sync2[gi] <= cmp_sync1[gi];
          cmp_prev[gi]  <= cmp_sync2[gi];
          irq_flags[gi] <= next_irq_flags[gi];
          o_irq_pending[gi] <= next_irq_flags[gi] && !irq_masks[gi];  // [R11]
        end
      end

      AST_FLAG_SET: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R14]
        cmp_event[gi] |=> irq_flags[gi])
        else $error("detection event did not set its request flag");

      AST_FLAG_STAYS: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R10]
        irq_flags[gi] && !wr_irq_flags |=> irq_flags[gi])
        else $error("request flag dropped without a software clear");

      AST_MASK_GATE: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R11]
        ##1 o_irq_pending[gi] == ($past(next_irq_flags[gi]) && !$past(irq_masks[gi])))
        else $error("pending output disagrees with flag and mask");

      AST_FLAG_CLEAR: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R10]
        wr_irq_flags && !i_wdata[gi] && !cmp_event[gi] |=> !irq_flags[gi])
        else $error("request flag survived a software clear");

      AST_FLAG_SW_SET: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R10]
        wr_irq_flags && i_wdata[gi] |=> irq_flags[gi])
        else $error("request flag not set by a software write");

      AST_MASK_BLOCK: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R11]
        irq_masks[gi] |=> !o_irq_pending[gi])
        else $error("masked request shown as pending");
    end
  endgenerate

  // read selection, unmapped offsets read zero
  assign rd_mux = sel_reset_ctl  ? reset_ctl :
                  sel_clock_gate ? clock_gate :
                  sel_dac_code   ? dac_code :
                  sel_amp_ctl    ? amp_ctl :
                  sel_cmp_mode   ? cmp_mode :
                  sel_irq_flags  ? {{(afecr_pkg::DATA_W-afecr_pkg::N_CMP){1'b0}}, irq_flags} :  // [R10]
                  sel_irq_masks  ? {{(afecr_pkg::DATA_W-afecr_pkg::N_CMP){1'b0}}, irq_masks} :
                                   afecr_pkg::RST_DAC_CODE;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= i_rd ? rd_mux : '0;
    end
  end

  assign o_dac_reset              = dac_hold;   // [R1]
  assign o_dac_clk_en             = dac_gate;   // [R2]
  assign o_amp_reset              = amp_hold;
  assign o_amp_clk_en             = amp_gate;
  assign o_amp_enable             = amp_ctl[afecr_pkg::AMP_ENABLE_BIT];
  assign o_feedback_ground_select = amp_ctl[afecr_pkg::GROUND_SEL_BIT];  // [R5]
  assign o_cmp_reset              = cmp_hold;   // [R12]
  assign o_cmp_clk_en             = cmp_gate;   // [R7]
  assign o_cmp_enable             = cmp_active;
  assign o_cmp_mode               = cmp_mode;

  AST_DAC_RELEASE: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R1]
    wr_reset_ctl |=> o_dac_reset == $past(i_wdata[afecr_pkg::DAC_RESET_BIT]))
    else $error("dac reset hold did not follow the write");

  AST_DAC_CLOCK: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R2]
    !o_dac_clk_en |=> o_dac_code == afecr_pkg::RST_DAC_CODE)
    else $error("dac code driven while its clock is stopped");

  AST_DAC_CODE: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R3]
    wr_dac_code && !dac_hold && !wr_reset_ctl && dac_gate && !wr_clock_gate ##1 !dac_hold
      |=> o_dac_code == $past(i_wdata, 2))
    else $error("dac output code does not match the written value");

  AST_AMP_LOCK: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R4]
    !amp_gate |=> $stable(amp_ctl))
    else $error("amplifier register changed while its clock is stopped");

  AST_GROUND_SEL: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R5]
    amp_wr_ok && !amp_init_ok |=> o_feedback_ground_select == $past(i_wdata[afecr_pkg::GROUND_SEL_BIT]))
    else $error("ground select did not take the written value");

  AST_GAIN_DECODE: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R6]
    amp_wr_ok && !amp_init_ok && i_wdata[1:0] == 2'h3 |=> ##1 o_gain_factor == afecr_pkg::GAIN_X32)
    else $error("gain code 11 did not give gain 32");

  AST_GAIN_LOW: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R6]
    amp_wr_ok && !amp_init_ok && i_wdata[1:0] == 2'h0 |=> ##1 o_gain_factor == afecr_pkg::GAIN_X4)
    else $error("gain code 00 did not give gain 4");

  AST_CMP_CLOCK: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R7]
    !o_cmp_clk_en |-> o_cmp_enable == 2'h0 && cmp_event == 2'h0)
    else $error("comparator active with its clock stopped");

  AST_CMP1_EN: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R8]
    wr_cmp_mode && !cmp_hold && cmp_gate && !wr_clock_gate && !wr_reset_ctl
      |=> o_cmp_enable[1] == $past(i_wdata[afecr_pkg::CMP_EN_BIT[1]]))
    else $error("comparator 1 enable did not follow the write");

  AST_CMP0_EN: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R9]
    wr_cmp_mode && !cmp_hold && cmp_gate && !wr_clock_gate && !wr_reset_ctl
      |=> o_cmp_enable[0] == $past(i_wdata[afecr_pkg::CMP_EN_BIT[0]]))
    else $error("comparator 0 enable did not follow the write");

  AST_CMP_HOLD: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R12]
    o_cmp_reset |=> o_cmp_mode == afecr_pkg::RST_CMP_MODE)
    else $error("comparator settings survive the module reset hold");

  AST_FLAG_READ: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R10]
    i_rd && sel_irq_flags |=> o_rdata[afecr_pkg::N_CMP-1:0] == $past(irq_flags))
    else $error("flag register read returned wrong flags");

  AST_DAC_HOLD_CLR: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R1]
    o_dac_reset |=> dac_code == afecr_pkg::RST_DAC_CODE)
    else $error("dac code register kept its value under reset hold");

  AST_DAC_RESET_HOLDS: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R1]
    !wr_reset_ctl |=> $stable(o_dac_reset))
    else $error("dac reset hold changed without a write");

  AST_DAC_GATE_WR: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R2]
    wr_clock_gate |=> o_dac_clk_en == $past(i_wdata[afecr_pkg::DAC_GATE_BIT]))
    else $error("dac clock gate did not follow the write");

  AST_DAC_REG_WR: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R3]
    wr_dac_code && !dac_hold |=> dac_code == $past(i_wdata))
    else $error("dac code register did not take the write");

  AST_AMP_INIT: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R4]
    amp_init_ok |=> amp_ctl == afecr_pkg::RST_AMP_CTL)
    else $error("amplifier register not initialized under reset hold");

  AST_AMP_WRITE: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R4]
    amp_wr_ok && !amp_init_ok |=> amp_ctl == ($past(i_wdata) & afecr_pkg::MASK_AMP_CTL))
    else $error("amplifier register did not take the write");

  AST_AMP_EN_WR: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R4]
    amp_wr_ok && !amp_init_ok |=> o_amp_enable == $past(i_wdata[afecr_pkg::AMP_ENABLE_BIT]))
    else $error("amplifier enable did not follow the write");

  AST_AMP_RESET_WR: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R4]
    wr_reset_ctl |=> o_amp_reset == $past(i_wdata[afecr_pkg::AMP_RESET_BIT]))
    else $error("amplifier reset hold did not follow the write");

  AST_GROUND_STAYS: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R5]
    !amp_wr_ok && !amp_init_ok |=> $stable(o_feedback_ground_select))
    else $error("ground select changed without a write");

  AST_GAIN_X8: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R6]
    amp_wr_ok && !amp_init_ok && i_wdata[1:0] == 2'h1 |=> ##1 o_gain_factor == afecr_pkg::GAIN_X8)
    else $error("gain code 01 did not give gain 8");

  AST_GAIN_X16: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R6]
    amp_wr_ok && !amp_init_ok && i_wdata[1:0] == 2'h2 |=> ##1 o_gain_factor == afecr_pkg::GAIN_X16)
    else $error("gain code 10 did not give gain 16");

  AST_CMP_GATE_WR: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R7]
    wr_clock_gate |=> o_cmp_clk_en == $past(i_wdata[afecr_pkg::CMP_GATE_BIT]))
    else $error("comparator clock gate did not follow the write");

  AST_CMP_MODE_WR: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R8] [R9]
    wr_cmp_mode && !cmp_hold |=> o_cmp_mode == $past(i_wdata))
    else $error("comparator mode register did not take the write");

  AST_MASK_WRITE: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R11]
    wr_irq_masks |=> irq_masks == $past(i_wdata[afecr_pkg::N_CMP-1:0]))
    else $error("mask register did not take the write");

  AST_CMP_RESET_WR: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R12]
    wr_reset_ctl |=> o_cmp_reset == $past(i_wdata[afecr_pkg::CMP_RESET_BIT]))
    else $error("comparator reset hold did not follow the write");

  AST_CMP_HOLD_OFF: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)  // [R12]
    o_cmp_reset |-> o_cmp_enable == '0)
    else $error("comparator enabled while the module is held in reset");

endmodule

//--- testbench/tb_afecr_regs.sv
// self-checking bench for the analog front end register bank
// assumes the register port takes strobes at the rising edge and answers reads one cycle later
`timescale 1ns/1ns
module tb_afecr_regs;
  logic                                i_clk_sys;
  logic                                i_arst_n;
  logic [afecr_pkg::ADDR_W-1:0]        i_addr;
  logic [afecr_pkg::DATA_W-1:0]        i_wdata;
  logic                                i_wr;
  logic                                i_rd;
  logic [afecr_pkg::DATA_W-1:0]        o_rdata;
  logic [afecr_pkg::N_CMP-1:0]         i_cmp_out;
  logic                                o_dac_reset;
  logic                                o_dac_clk_en;
  logic [afecr_pkg::DATA_W-1:0]        o_dac_code;
  logic                                o_amp_reset;
  logic                                o_amp_clk_en;
  logic                                o_amp_enable;
  logic                                o_feedback_ground_select;
  logic [afecr_pkg::GAIN_FACT_W-1:0]   o_gain_factor;
  logic                                o_cmp_reset;
  logic                                o_cmp_clk_en;
  logic [afecr_pkg::N_CMP-1:0]         o_cmp_enable;
  logic [afecr_pkg::DATA_W-1:0]        o_cmp_mode;
  logic [afecr_pkg::N_CMP-1:0]         o_irq_pending;
  int                                  err_total;
  int                                  checks_done;
  logic [7:0]                          rv;
  logic [7:0]                          gexp;

  afecr_regs i_afecr_regs (
    .i_clk_sys                (i_clk_sys),
    .i_arst_n                 (i_arst_n),
    .i_addr                   (i_addr),
    .i_wdata                  (i_wdata),
    .i_wr                     (i_wr),
    .i_rd                     (i_rd),
    .o_rdata                  (o_rdata),
    .i_cmp_out                (i_cmp_out),
    .o_dac_reset              (o_dac_reset),
    .o_dac_clk_en             (o_dac_clk_en),
    .o_dac_code               (o_dac_code),
    .o_amp_reset              (o_amp_reset),
    .o_amp_clk_en             (o_amp_clk_en),
    .o_amp_enable             (o_amp_enable),
    .o_feedback_ground_select (o_feedback_ground_select),
    .o_gain_factor            (o_gain_factor),
    .o_cmp_reset              (o_cmp_reset),
    .o_cmp_clk_en             (o_cmp_clk_en),
    .o_cmp_enable             (o_cmp_enable),
    .o_cmp_mode               (o_cmp_mode),
    .o_irq_pending            (o_irq_pending)
  );

  initial i_clk_sys = 1'b0;
  always #20 i_clk_sys = ~i_clk_sys;

  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd   <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  task automatic rchk(input string nm, input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(nm, exp, d);
  endtask

  // let register and decoded outputs land
  task automatic settle;
    repeat (2) @(posedge i_clk_sys);
    #1;
  endtask

  initial begin
    #200000;
    err_total++;
    end_sim();
  end

  initial begin
    err_total = 0;
    checks_done = 0;
    i_arst_n = 1'b0;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_cmp_out = 2'h0;
    repeat (12) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    // reset values
    rchk("reset_ctl", afecr_pkg::OFS_RESET_CTL, 8'h00);
    rchk("clock_gate", afecr_pkg::OFS_CLOCK_GATE, 8'h00);
    rchk("irq_flags", afecr_pkg::OFS_IRQ_FLAGS, 8'h00);
    rchk("irq_masks", afecr_pkg::OFS_IRQ_MASKS, 8'h03);
    rchk("unmapped", 4'h9, 8'h00);
    wr(afecr_pkg::OFS_IRQ_FLAGS, 8'h00);
    wr(afecr_pkg::OFS_IRQ_MASKS, 8'h03);
    // amplifier register refused while its gate is off
    wr(afecr_pkg::OFS_AMP_CTL, 8'h8b);
    rchk("amp_locked", afecr_pkg::OFS_AMP_CTL, 8'h00);
    wr(afecr_pkg::OFS_CLOCK_GATE, 8'hff);
    rchk("clock_gate_rw", afecr_pkg::OFS_CLOCK_GATE, 8'ha4);
    settle();
    chk("gates", 8'h07, {5'h0, o_dac_clk_en, o_cmp_clk_en, o_amp_clk_en});
    // dac code and reset hold
    wr(afecr_pkg::OFS_DAC_CODE, 8'h5a);
    settle();
    chk("dac_code_out", 8'h5a, o_dac_code);
    rchk("dac_code", afecr_pkg::OFS_DAC_CODE, 8'h5a);
    wr(afecr_pkg::OFS_RESET_CTL, 8'h80);
    settle();
    chk("dac_reset", 8'h01, {7'h0, o_dac_reset});
    chk("dac_code_held", 8'h00, o_dac_code);
    rchk("dac_code_clr", afecr_pkg::OFS_DAC_CODE, 8'h00);
    wr(afecr_pkg::OFS_RESET_CTL, 8'h00);
    wr(afecr_pkg::OFS_DAC_CODE, 8'ha3);
    settle();
    chk("dac_code_rel", 8'ha3, o_dac_code);
    // every gain code and both ground choices, ground select following the low gain bit
    for (int g = 0; g < 4; g++) begin
      wr(afecr_pkg::OFS_AMP_CTL, {1'b1, 3'h0, g[0], 1'b0, g[1:0]});
      settle();
      gexp = 8'h04 << g;
      chk("gain", gexp, {2'h0, o_gain_factor});
      chk("ground", {7'h0, g[0]}, {7'h0, o_feedback_ground_select});
      chk("amp_en", 8'h01, {7'h0, o_amp_enable});
      rchk("amp_ctl", afecr_pkg::OFS_AMP_CTL, {1'b1, 3'h0, g[0], 1'b0, g[1:0]});
    end
    wr(afecr_pkg::OFS_RESET_CTL, 8'h04);
    settle();
    chk("amp_reset", 8'h01, {7'h0, o_amp_reset});
    rchk("amp_ctl_clr", afecr_pkg::OFS_AMP_CTL, 8'h00);
    wr(afecr_pkg::OFS_RESET_CTL, 8'h00);
    // comparator enables
    wr(afecr_pkg::OFS_CMP_MODE, 8'h10);
    settle();
    chk("cmp_en_one", 8'h02, {6'h0, o_cmp_enable});
    wr(afecr_pkg::OFS_CMP_MODE, 8'h11);
    settle();
    chk("cmp_en_both", 8'h03, {6'h0, o_cmp_enable});
    chk("cmp_mode", 8'h11, o_cmp_mode);
    // detection while masked sets both flags but nothing pends
    @(posedge i_clk_sys);
    i_cmp_out <= 2'h3;
    repeat (6) @(posedge i_clk_sys);
    #1;
    chk("pend_masked", 8'h00, {6'h0, o_irq_pending});
    rchk("flag_set", afecr_pkg::OFS_IRQ_FLAGS, 8'h03);
    wr(afecr_pkg::OFS_IRQ_MASKS, 8'h00);
    settle();
    chk("pend_open", 8'h03, {6'h0, o_irq_pending});
    wr(afecr_pkg::OFS_IRQ_MASKS, 8'h01);
    settle();
    chk("pend_remask", 8'h02, {6'h0, o_irq_pending});
    rchk("flag_stays", afecr_pkg::OFS_IRQ_FLAGS, 8'h03);
    wr(afecr_pkg::OFS_IRQ_FLAGS, 8'h00);
    rchk("flag_clr", afecr_pkg::OFS_IRQ_FLAGS, 8'h00);
    @(posedge i_clk_sys);
    i_cmp_out <= 2'h0;
    // comparator 1 disabled ignores its event
    wr(afecr_pkg::OFS_CMP_MODE, 8'h01);
    i_cmp_out <= 2'h2;
    repeat (6) @(posedge i_clk_sys);
    rchk("flag_off", afecr_pkg::OFS_IRQ_FLAGS, 8'h00);
    @(posedge i_clk_sys);
    i_cmp_out <= 2'h0;
    // comparator module reset hold
    wr(afecr_pkg::OFS_RESET_CTL, 8'h20);
    settle();
    chk("cmp_reset", 8'h01, {7'h0, o_cmp_reset});
    chk("cmp_en_held", 8'h00, {6'h0, o_cmp_enable});
    rchk("cmp_mode_clr", afecr_pkg::OFS_CMP_MODE, 8'h00);
    wr(afecr_pkg::OFS_RESET_CTL, 8'h00);
    wr(afecr_pkg::OFS_CMP_MODE, 8'h01);
    settle();
    chk("cmp_rel", 8'h01, {6'h0, o_cmp_enable});
    // stopped clocks, and an amplifier reset hold with its clock off
    wr(afecr_pkg::OFS_AMP_CTL, 8'h89);
    wr(afecr_pkg::OFS_CLOCK_GATE, 8'h00);
    wr(afecr_pkg::OFS_RESET_CTL, 8'h04);
    settle();
    chk("dac_stopped", 8'h00, o_dac_code);
    chk("cmp_stopped", 8'h00, {6'h0, o_cmp_enable});
    rchk("amp_kept", afecr_pkg::OFS_AMP_CTL, 8'h89);
    rd(4'hf, rv);
    chk("unmapped_hi", 8'h00, rv);
    end_sim();
  end
endmodule
